// ### design/uorm_pkg.sv
// Purpose: Constants for the USB OTG controller register bank
// Assumes: APB, 32-bit data, one aligned word per register
// Notes:   Register bits live in the low byte only
package uorm_pkg;

	localparam int ADDR_W = 8;

	// ==========================================================
	// Register group sizes, descriptor count and frame width
	localparam int NUM_CTRL   = 12;
	localparam int NUM_IRQ    = 7;
	localparam int NUM_EP     = 16;
	localparam int NUM_PWR    = 2;
	localparam int NUM_REGS   = NUM_CTRL + NUM_IRQ + NUM_EP + NUM_PWR;
	localparam int NUM_DESC   = 128;
	localparam int FRAME_W    = 11;

	// ==========================================================
	// Byte offsets of each group
	localparam logic [7:0] OFF_CTRL_BASE = 8'h00;
	localparam logic [7:0] OFF_IRQ_BASE  = 8'h30;
	localparam logic [7:0] OFF_EP_BASE   = 8'h4c;
	localparam logic [7:0] OFF_PWR_BASE  = 8'h8c;

	// Control group slots of named registers
	localparam logic [7:0] OFF_DESC_PAGE_1  = 8'h00;
	localparam logic [7:0] OFF_DESC_PAGE_2  = 8'h04;
	localparam logic [7:0] OFF_DESC_PAGE_3  = 8'h08;
	localparam logic [7:0] OFF_FRAME_LOW    = 8'h0c;
	localparam logic [7:0] OFF_FRAME_HIGH   = 8'h10;
	localparam logic [7:0] OFF_HOST_ONLY    = 8'h14;
	localparam logic [7:0] OFF_MODE_CTRL    = 8'h18;

	// ==========================================================
	// Field positions, write masks, widths and reset values
	localparam int         HOST_MODE_BIT   = 0;
	localparam logic [7:0] PAGE_ALIGN_MASK = 8'hfe;
	localparam logic [7:0] REG_RESET       = 8'h00;
	localparam logic [7:0] HOST_ONLY_MASK  = 8'h7f;
	localparam logic [7:0] PERIPH_MASK     = 8'h0f;
	localparam logic [2:0] FRAME_HIGH_W    = 3'h3;

endpackage : uorm_pkg

// ### design/uorm_byte_reg.sv
// Purpose: One low-byte register with write mask
// Assumes: Write strobe from the APB decode
// Notes:   Bits outside the mask are cleared on each write
`timescale 1ns/1ns
module uorm_byte_reg (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       wrEn,
	input  wire logic [7:0] wrMask,
	input  wire logic [7:0] wrData,
	output logic      [7:0] value
);
	logic [7:0] value_r;
	logic [7:0] value_nxt;

	assign value_nxt = wrEn ? (wrData & wrMask) : value_r;
	assign value     = value_r;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			value_r <= uorm_pkg::REG_RESET;
		end else begin
			value_r <= value_nxt;
		end
	end
endmodule // uorm_byte_reg

// ### design/uorm_register_map.sv
// Purpose: APB register bank of a USB OTG controller
// Assumes: Frame counter comes from same-clock link logic
// Notes:   Zero-wait APB, unmapped addresses read zero with pslverr
`timescale 1ns/1ns
module uorm_register_map #(
	parameter int DESC_ENTRIES = uorm_pkg::NUM_DESC
) (
	input  wire logic                        clk,
	input  wire logic                        rstn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [uorm_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                 pwdata,
	input  wire logic [3:0]                  pstrb,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic [uorm_pkg::FRAME_W-1:0] frameCount,
	output logic                             hostMode,
	output logic      [7:0]                  descPage1,
	output logic      [7:0]                  descPage2,
	output logic      [7:0]                  descPage3,
	output logic      [7:0]                  descEntries
);
	// ==========================================================
	// Bus decode
	logic                 access;
	logic                 wrStrobe;
	logic [5:0]           regIdx;
	logic                 aligned;
	logic                 inRange;
	logic                 hostOnlyHit;
	logic                 mapped;
	logic [uorm_pkg::NUM_REGS-1:0] regWr;
	logic [7:0]           regVal [uorm_pkg::NUM_REGS];
	logic [7:0]           regMask [uorm_pkg::NUM_REGS];
	logic [7:0]           readByte;
	logic [31:0]          prdata_r;
	logic                 pslverr_r;
	logic [7:0]           frameLow;
	logic [7:0]           frameHigh;
	logic [3:0]           groupHit;
	logic                 frameLowHit;
	logic                 frameHighHit;
	logic [7:0]           regReadByte;
	logic [uorm_pkg::NUM_REGS-1:0] slotSel;
	logic [uorm_pkg::NUM_REGS-1:0] isPage;
	logic [uorm_pkg::NUM_REGS-1:0] isFrame;
	logic [uorm_pkg::NUM_REGS-1:0] isHostOnly;
	logic [uorm_pkg::NUM_REGS-1:0] isMode;
	logic [7:0]           slotView [uorm_pkg::NUM_REGS];
	logic [7:0]           slotOr   [uorm_pkg::NUM_REGS];

	assign access   = psel & penable;
	assign regIdx   = paddr[7:2];
	assign aligned  = (paddr[1:0] == 2'h0);
	assign inRange  = (regIdx < 6'(uorm_pkg::NUM_REGS));

	// ==========================================================
	// Group decode
	// group membership by address range
	assign groupHit[0] = (paddr < uorm_pkg::OFF_IRQ_BASE);
	assign groupHit[1] = (paddr >= uorm_pkg::OFF_IRQ_BASE) & (paddr < uorm_pkg::OFF_EP_BASE);
	assign groupHit[2] = (paddr >= uorm_pkg::OFF_EP_BASE) & (paddr < uorm_pkg::OFF_PWR_BASE);
	assign groupHit[3] = (paddr >= uorm_pkg::OFF_PWR_BASE) & inRange;

	// ==========================================================
	// Mode and access qualification
	assign hostMode = regVal[uorm_pkg::OFF_MODE_CTRL[7:2]][uorm_pkg::HOST_MODE_BIT];
	// host-only slot absent in peripheral mode
	assign hostOnlyHit = (paddr == uorm_pkg::OFF_HOST_ONLY) & ~hostMode;
	assign mapped   = aligned & (|groupHit) & ~hostOnlyHit;
	assign wrStrobe = access & pwrite & mapped & pstrb[0];

	// ==========================================================
	// Register array
	// one slot per register across all four groups
	genvar gi;
	generate
		for (gi = 0; gi < uorm_pkg::NUM_REGS; gi++) begin : gReg
			localparam logic [7:0] OFF = 8'(gi * 4);
			assign slotSel[gi] = (regIdx == 6'(gi));
			assign regWr[gi]   = wrStrobe & slotSel[gi];

			assign isPage[gi] = (OFF == uorm_pkg::OFF_DESC_PAGE_1) ||
				(OFF == uorm_pkg::OFF_DESC_PAGE_2) ||
				(OFF == uorm_pkg::OFF_DESC_PAGE_3);
			assign isFrame[gi] = (OFF == uorm_pkg::OFF_FRAME_LOW) ||
				(OFF == uorm_pkg::OFF_FRAME_HIGH);
			assign isHostOnly[gi] = (OFF == uorm_pkg::OFF_HOST_ONLY);
			assign isMode[gi]     = (OFF == uorm_pkg::OFF_MODE_CTRL);

			// page pointer bit 0 held at zero
			assign regMask[gi] =
				isPage[gi]     ? uorm_pkg::PAGE_ALIGN_MASK :
				isFrame[gi]    ? 8'h00 :
				isHostOnly[gi] ? uorm_pkg::HOST_ONLY_MASK :
				isMode[gi]     ? 8'hff :
				(hostMode ? 8'hff : uorm_pkg::PERIPH_MASK);
			uorm_byte_reg uReg (
				.clk    (clk),
				.rstn   (rstn),
				.wrEn   (regWr[gi]),
				.wrMask (regMask[gi]),
				.wrData (pwdata[7:0]),
				.value  (regVal[gi])
			);

			// mode-dependent view of the selected slot
			assign slotView[gi] = slotSel[gi] ? (regVal[gi] & regMask[gi]) : 8'h00;
		end
	endgenerate

	// ==========================================================
	// Read select as an OR chain, no out-of-range index
	assign slotOr[0] = slotView[0];
	generate
		for (gi = 1; gi < uorm_pkg::NUM_REGS; gi++) begin : gOr
			assign slotOr[gi] = slotOr[gi-1] | slotView[gi];
		end
	endgenerate
	assign regReadByte = slotOr[uorm_pkg::NUM_REGS-1];

	// ==========================================================
	// Frame count and read mux
	// low byte bits 7..0, high byte bits 10..8
	assign frameLow  = frameCount[7:0];
	assign frameHigh = {5'h00, frameCount[uorm_pkg::FRAME_W-1:8]};
	assign frameLowHit  = (paddr == uorm_pkg::OFF_FRAME_LOW);
	assign frameHighHit = (paddr == uorm_pkg::OFF_FRAME_HIGH);
	assign readByte =
		!mapped      ? 8'h00 :
		frameLowHit  ? frameLow :
		frameHighHit ? frameHigh :
		regReadByte;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else begin
			prdata_r  <= (psel & ~penable & ~pwrite) ? {24'h000000, readByte} : prdata_r;
			pslverr_r <= (psel & ~penable) ? ~mapped : pslverr_r;
		end
	end

	assign pready  = 1'b1;
	assign prdata  = prdata_r;
	assign pslverr = access & pslverr_r;

	assign descPage1 = regVal[uorm_pkg::OFF_DESC_PAGE_1[7:2]];
	assign descPage2 = regVal[uorm_pkg::OFF_DESC_PAGE_2[7:2]];
	assign descPage3 = regVal[uorm_pkg::OFF_DESC_PAGE_3[7:2]];
	// table capacity advertised to the memory side
	assign descEntries = 8'(DESC_ENTRIES);
endmodule // uorm_register_map

// ### sim/uorm_register_map_sva.sv
// Purpose: Port checks for the register bank
// Assumes: Zero-wait APB, read data latched in setup
// Notes:   Bound from the testbench top file
`timescale 1ns/1ns
module uorm_register_map_sva (
	input wire logic                         clk,
	input wire logic                         rstn,
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [uorm_pkg::ADDR_W-1:0]  paddr,
	input wire logic [31:0]                  pwdata,
	input wire logic [3:0]                   pstrb,
	input wire logic [31:0]                  prdata,
	input wire logic                         pslverr,
	input wire logic [uorm_pkg::FRAME_W-1:0] frameCount,
	input wire logic                         hostMode,
	input wire logic [7:0]                   descPage1,
	input wire logic [7:0]                   descEntries
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire acc = psel && penable;
	wire rdSet = psel && !penable && !pwrite;
	AST_UNMAPPED: assert property (acc && paddr >= 8'h94 |-> pslverr)
		else $error("unmapped access not flagged");
	AST_ENTRIES: assert property (descEntries == 8'h80)
		else $error("descriptor entry count wrong");
	AST_LOW_BYTE: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bytes not zero");
	AST_HOST_ONLY: assert property (acc && paddr == 8'h14 && !hostMode |-> pslverr)
		else $error("host-only register open in peripheral mode");
	AST_PAGE_WR: assert property (acc && pwrite && pstrb[0] && paddr == 8'h00
		|=> descPage1 == ($past(pwdata[7:0]) & 8'hfe)) else $error("page write wrong");
	AST_FRAME_LOW: assert property (rdSet && paddr == 8'h0c
		|=> prdata == {24'h0, $past(frameCount[7:0])}) else $error("frame low wrong");
	AST_FRAME_HIGH: assert property (rdSet && paddr == 8'h10
		|=> prdata == {29'h0, $past(frameCount[10:8])}) else $error("frame high wrong");
endmodule // uorm_register_map_sva

// ### sim/usb_otg_register_map_test.sv
// Purpose: Self-checking bench of the register bank
// Assumes: Zero-wait APB slave, byte addresses
// Notes:   Random page data and frame counts, fixed seed
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module usb_otg_register_map_test;
	logic        clk, rstn, psel, penable, pwrite, pready, pslverr, hostMode, err;
	logic [7:0]  paddr, descPage1, descPage2, descPage3, descEntries;
	logic [3:0]  pstrb, strb;
	logic [31:0] pwdata, prdata, rd, d;
	logic [10:0] frameCount;
	int          failures, n_checks;
	integer      seed = 32'hb84bf77e;
	uorm_register_map u_dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .frameCount, .hostMode, .descPage1,
		.descPage2, .descPage3, .descEntries);
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd; pstrb <= strb;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0; penable <= 0;
	endtask
	function automatic logic [31:0] exp_page(input logic [31:0] v);
		return {24'h000000, v[7:0] & uorm_pkg::PAGE_ALIGN_MASK};
	endfunction
	task print_verdict;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	initial begin
		#100000 failures++;
		print_verdict;
	end
	initial begin
		rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; frameCount = 0;
		pstrb = 0; strb = 4'hf;
		repeat (16) @(posedge clk);
		rstn <= 1;
		for (int i = 0; i < 3; i++) begin
			apb(0, 8'(4 * i), 0); `CHK(rd, 32'h0)
		end
		repeat (20) for (int i = 0; i < 3; i++) begin
			d = $random(seed);
			apb(1, 8'(4 * i), d);
			apb(0, 8'(4 * i), 0); `CHK(rd, exp_page(d))
		end
		// Upper lanes only: write must not land
		strb = 4'he;
		apb(1, 8'h08, 32'hffff_ffff); `CHK(err, 1'b0)
		strb = 4'hf;
		apb(0, 8'h08, 0); `CHK(rd, exp_page(d))
		apb(1, 8'h00, 32'h13); apb(1, 8'h04, 32'h27); apb(1, 8'h08, 32'h3b);
		@(posedge clk);
		`CHK(descPage1, 8'h12)
		`CHK(descPage2, 8'h26)
		`CHK(descPage3, 8'h3a)
		repeat (10) begin
			frameCount <= 11'($random(seed));
			apb(0, 8'h0c, 0); `CHK(rd, {24'h0, frameCount[7:0]})
			apb(0, 8'h10, 0); `CHK(rd, {29'h0, frameCount[10:8]})
		end
		apb(1, 8'h14, 32'hff); `CHK(err, 1'b1)
		apb(0, 8'h94, 0); `CHK(err, 1'b1)
		`CHK(rd, 32'h0)
		apb(0, 8'h90, 0); `CHK(err, 1'b0)
		apb(0, 8'h01, 0); `CHK(err, 1'b1)
		`CHK(rd, 32'h0)
		apb(1, 8'h30, 32'hffff); apb(0, 8'h30, 0); `CHK(rd, 32'hf)
		apb(1, 8'h18, 32'h1);
		apb(1, 8'h14, 32'hff); apb(0, 8'h14, 0); `CHK(rd, 32'h7f)
		`CHK(hostMode, 1'b1)
		`CHK(descEntries, 8'h80)
		print_verdict;
	end
endmodule // usb_otg_register_map_test
bind uorm_register_map uorm_register_map_sva u_sva (.clk, .rstn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .prdata, .pslverr, .frameCount, .hostMode, .descPage1,
	.descEntries);
